// >>> common/tpq_regs.svh
// Register offsets, reset values and timing counts of the pause quanta/resend control
`ifndef TPQ_REGS_SVH
`define TPQ_REGS_SVH

// Register byte offsets on APB
`define TPQ_ADDR_CTRL         12'h000
`define TPQ_ADDR_ENABLE       12'h004
`define TPQ_ADDR_STATUS       12'h008
`define TPQ_ADDR_QUANTA_BASE  12'h040
`define TPQ_ADDR_REFRESH_BASE 12'h080

// Field positions
`define TPQ_CTRL_RESEND_BIT   0
`define TPQ_STAT_PEND_LSB     0
`define TPQ_STAT_ACT_LSB      16

// Reset values
`define TPQ_RST_ENABLE        9'h000
`define TPQ_RST_QUANTA        16'hFFFF
`define TPQ_RST_REFRESH       16'h7FFF

// Timing: one pause quantum is 512 bit times, 10240 ps at 50 Gb/s
`define TPQ_CLK_PS            20000
`define TPQ_QUANTUM_PS        10240
`define TPQ_QUANTUM_CYC       ((`TPQ_QUANTUM_PS / `TPQ_CLK_PS) < 1 ? 1 : (`TPQ_QUANTUM_PS / `TPQ_CLK_PS))

`endif

// >>> common/tpq_pkg.sv
// Types shared by the pause quanta/resend control
package tpq_pkg;

    // Pause frame launcher states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_OFFER
    } tpq_tx_state_t;

endpackage : tpq_pkg

// >>> core/tpq_refresh_timer.sv
// Per-class pause refresh interval counter
`timescale 1ns/10ps
module tpq_refresh_timer #(
    parameter int QW = 16
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Control
    input  wire logic          active,
    input  wire logic          restart,
    input  wire logic          tick,
    input  wire logic [QW-1:0] interval,
    // Event
    output logic               expire
);

    logic [QW-1:0] count_ff;
    logic          wrap;

    // A zero interval disables retransmission rather than firing every quantum
    assign wrap   = tick && (interval != '0) && (count_ff == interval - 1'b1);
    assign expire = active && !restart && wrap;

    // Count quanta from zero; restart or inactivity holds the count at zero
    always_ff @(posedge mclk) begin
        if (reset || !active || restart) begin
            count_ff <= '0;
        end else if (wrap) begin
            count_ff <= '0;
        end else if (tick) begin
            count_ff <= count_ff + 1'b1;
        end
    end

endmodule : tpq_refresh_timer

// >>> core/tpq_ctrl.sv
// Transmit pause quanta selection, refresh and resend control with APB registers
//
// Function
// - resend retransmits pending pause after current packet
// - resend also clears the retransmit counters
// - nine 16-bit quanta, inserted per class
// - quanta index 8 serves global pause only
// - quanta 0 to 7 serve priorities 0 to 7
// - quanta from ports, or registers when bus-mapped
// - each request bit triggers its class packet
// - per-class enable gates pause packet transmission
// - per-class refresh interval sets retransmit spacing
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "tpq_regs.svh"
module tpq_ctrl import tpq_pkg::*; #(
    parameter int NCLS   = 9,
    parameter int QW     = 16,
    parameter bit REG_IF = 1'b0
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // Pause controls from user logic
    input  wire logic [NCLS-1:0]          pause_req,
    input  wire logic [NCLS-1:0]          pause_enable,
    input  wire logic                     resend_pause,
    input  wire logic [NCLS-1:0][QW-1:0]  pause_quanta,
    input  wire logic [NCLS-1:0][QW-1:0]  refresh_timer,
    // Transmit datapath
    input  wire logic                     pkt_in_flight,
    input  wire logic                     pause_tx_ready,
    output logic                          pause_tx_valid,
    output logic                          pause_tx_global,
    output logic [3:0]                    pause_tx_class,
    output logic [QW-1:0]                 pause_tx_quanta,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr
);

    localparam int GIDX = NCLS - 1;

    logic [NCLS-1:0]         enable_ff;
    logic [NCLS-1:0][QW-1:0] quanta_ff;
    logic [NCLS-1:0][QW-1:0] refresh_ff;
    logic [NCLS-1:0]         pending_ff;
    logic [NCLS-1:0]         nxt_pending;
    logic [NCLS-1:0]         active_ff;
    logic [NCLS-1:0]         expire;
    logic [NCLS-1:0]         sent;
    logic [NCLS-1:0]         eff_enable;
    logic [NCLS-1:0][QW-1:0] eff_quanta;
    logic [NCLS-1:0][QW-1:0] eff_refresh;
    logic [NCLS-1:0]         active;
    logic [NCLS-1:0]         new_act;
    logic                    sw_resend_ff;
    logic                    resend_hit;
    logic [15:0]             tick_cnt_ff;
    logic                    tick;
    logic [3:0]              pick;
    logic                    launch;
    tpq_tx_state_t           state_ff;
    logic                    wr_en;
    logic                    setup_rd;
    logic [4:0]              q_slot;
    logic [4:0]              r_slot;
    logic                    addr_ok;
    logic [31:0]             rd_mux;

    // Decode a nine-word register bank: bit 4 is the hit, bits 3:0 the slot
    function automatic logic [4:0] slot_hit(input logic [11:0] addr,
                                            input logic [11:0] base);
        logic hit;
        hit = (addr[11:6] == base[11:6]) && (addr[1:0] == 2'h0)
              && (int'(addr[5:2]) < NCLS);
        return {hit, addr[5:2]};
    endfunction : slot_hit

    // Highest pending class wins so global pause goes out before priorities
    function automatic logic [3:0] pick_class(input logic [NCLS-1:0] vec);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < NCLS; i++) begin
            if (vec[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : pick_class

    // Settings come from registers when bus-mapped, otherwise from the ports
    assign eff_enable  = REG_IF ? enable_ff  : pause_enable;
    assign eff_quanta  = REG_IF ? quanta_ff  : pause_quanta;
    assign eff_refresh = REG_IF ? refresh_ff : refresh_timer;

    // A class is live while requested and enabled
    assign active     = pause_req & eff_enable;
    assign new_act    = active & ~active_ff;
    // The port is expected to pulse once; a held level repeats the restart
    assign resend_hit = resend_pause | sw_resend_ff;

    // Remember last cycle's live classes to spot a fresh request
    always_ff @(posedge mclk) begin
        if (reset) begin
            active_ff <= '0;
        end else begin
            active_ff <= active;
        end
    end

    // Quantum prescaler shared by all refresh timers
    assign tick = (tick_cnt_ff == 16'(`TPQ_QUANTUM_CYC - 1));
    always_ff @(posedge mclk) begin
        if (reset || tick) begin
            tick_cnt_ff <= 16'h0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
    end

    // One refresh timer per class; resend, a fresh request or a send restarts it
    for (genvar g = 0; g < NCLS; g++) begin : g_timer
        tpq_refresh_timer #(
            .QW (QW)
        ) u_timer (
            .mclk     (mclk),
            .reset    (reset),
            .active   (active[g]),
            .restart  (resend_hit | new_act[g] | sent[g]),
            .tick     (tick),
            .interval (eff_refresh[g]),
            .expire   (expire[g])
        );
    end

    // Pending set wins over the send clear; dropped classes lose their claim
    always_comb begin
        nxt_pending = (pending_ff & ~sent) | new_act | expire;
        if (resend_hit) begin
            nxt_pending = nxt_pending | active_ff;
        end
        nxt_pending = nxt_pending & active;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pending_ff <= '0;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // Launch only between packets so a pause never cuts into one in flight
    assign pick   = pick_class(pending_ff);
    assign launch = (state_ff == ST_IDLE) && (|pending_ff) && !pkt_in_flight;
    always_comb begin
        sent = '0;
        if (launch) begin
            sent[pick] = 1'b1;
        end
    end

    // Pause frame offer: fields frozen until the datapath takes them
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff        <= ST_IDLE;
            pause_tx_valid  <= 1'b0;
            pause_tx_global <= 1'b0;
            pause_tx_class  <= 4'h0;
            pause_tx_quanta <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (launch) begin
                        state_ff        <= ST_OFFER;
                        pause_tx_valid  <= 1'b1;
                        pause_tx_class  <= pick;
                        pause_tx_global <= (int'(pick) == GIDX);
                        pause_tx_quanta <= eff_quanta[pick];
                    end
                end
                ST_OFFER: begin
                    if (pause_tx_ready) begin
                        state_ff       <= ST_IDLE;
                        pause_tx_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // APB decode: zero wait states, unmapped addresses answer with an error
    assign q_slot   = slot_hit(paddr, `TPQ_ADDR_QUANTA_BASE);
    assign r_slot   = slot_hit(paddr, `TPQ_ADDR_REFRESH_BASE);
    assign addr_ok  = q_slot[4] || r_slot[4] || (paddr == `TPQ_ADDR_CTRL)
                      || (paddr == `TPQ_ADDR_ENABLE) || (paddr == `TPQ_ADDR_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign setup_rd = psel && !penable && !pwrite;

    // Software resend is a one-cycle pulse per write of the control bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            sw_resend_ff <= 1'b0;
        end else begin
            sw_resend_ff <= wr_en && (paddr == `TPQ_ADDR_CTRL)
                            && pwdata[`TPQ_CTRL_RESEND_BIT];
        end
    end

    // Writable settings
    always_ff @(posedge mclk) begin
        if (reset) begin
            enable_ff <= NCLS'(`TPQ_RST_ENABLE);
            for (int i = 0; i < NCLS; i++) begin
                quanta_ff[i]  <= QW'(`TPQ_RST_QUANTA);
                refresh_ff[i] <= QW'(`TPQ_RST_REFRESH);
            end
        end else if (wr_en) begin
            if (paddr == `TPQ_ADDR_ENABLE) begin
                enable_ff <= pwdata[NCLS-1:0];
            end
            if (q_slot[4]) begin
                quanta_ff[q_slot[3:0]] <= pwdata[QW-1:0];
            end
            if (r_slot[4]) begin
                refresh_ff[r_slot[3:0]] <= pwdata[QW-1:0];
            end
        end
    end

    // Read mux; status shows pending and live classes
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == `TPQ_ADDR_ENABLE) begin
            rd_mux[NCLS-1:0] = enable_ff;
        end else if (paddr == `TPQ_ADDR_STATUS) begin
            rd_mux[`TPQ_STAT_PEND_LSB +: NCLS] = pending_ff;
            rd_mux[`TPQ_STAT_ACT_LSB +: NCLS]  = active;
        end else if (q_slot[4]) begin
            rd_mux[QW-1:0] = quanta_ff[q_slot[3:0]];
        end else if (r_slot[4]) begin
            rd_mux[QW-1:0] = refresh_ff[r_slot[3:0]];
        end
    end

    // Read data captured in the setup cycle so it is a flop in the access cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= rd_mux;
        end
    end

endmodule : tpq_ctrl

// >>> tb/tpq_ctrl_monitor.sv
// Checker for the pause offer port of tpq_ctrl
`timescale 1ns/10ps
module tpq_ctrl_monitor import tpq_pkg::*; #(
    parameter int NCLS = 9,
    parameter int QW   = 16
) (
    // Clock, reset and user controls
    input wire logic                    mclk,
    input wire logic                    reset,
    input wire logic [NCLS-1:0]         pause_req,
    input wire logic [NCLS-1:0]         pause_enable,
    input wire logic                    resend_pause,
    input wire logic [NCLS-1:0][QW-1:0] pause_quanta,
    // Offer port
    input wire logic                    pkt_in_flight,
    input wire logic                    pause_tx_ready,
    input wire logic                    pause_tx_valid,
    input wire logic                    pause_tx_global,
    input wire logic [3:0]              pause_tx_class,
    input wire logic [QW-1:0]           pause_tx_quanta
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_glob;
        pause_tx_valid |-> pause_tx_global == (pause_tx_class == 4'h8);
    endproperty
    a_glob: assert property (p_glob) else $error("global flag wrong");
    property p_quanta;
        $rose(pause_tx_valid) |-> pause_tx_quanta == pause_quanta[pause_tx_class];
    endproperty
    a_quanta: assert property (p_quanta) else $error("quanta wrong");
    property p_hold;
        pause_tx_valid && !pause_tx_ready |=>
            pause_tx_valid && $stable(pause_tx_class) && $stable(pause_tx_quanta);
    endproperty
    a_hold: assert property (p_hold) else $error("offer not held");
    property p_drop;
        pause_tx_valid && pause_tx_ready |=> !pause_tx_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("offer repeated");
    property p_fly;
        $rose(pause_tx_valid) |-> !$past(pkt_in_flight);
    endproperty
    a_fly: assert property (p_fly) else $error("launch in packet");
    property p_en;
        $rose(pause_tx_valid) |-> pause_enable[pause_tx_class];
    endproperty
    a_en: assert property (p_en) else $error("disabled class sent");
    property p_req;
        $rose(pause_req[8]) && pause_enable[8] && !pause_tx_valid && !pkt_in_flight
            |-> ##[2:12] pause_tx_valid && pause_tx_global;
    endproperty
    a_req: assert property (p_req) else $error("global request lost");
    property p_rsd;
        resend_pause && pause_req[8] && pause_enable[8] && !pkt_in_flight
            |-> ##[1:12] pause_tx_valid && pause_tx_global;
    endproperty
    a_rsd: assert property (p_rsd) else $error("resend lost");
endmodule : tpq_ctrl_monitor

bind tpq_ctrl tpq_ctrl_monitor #(.NCLS(NCLS), .QW(QW)) u_mon (
    .mclk(mclk), .reset(reset), .pause_req(pause_req), .pause_enable(pause_enable),
    .resend_pause(resend_pause), .pause_quanta(pause_quanta),
    .pkt_in_flight(pkt_in_flight), .pause_tx_ready(pause_tx_ready),
    .pause_tx_valid(pause_tx_valid), .pause_tx_global(pause_tx_global),
    .pause_tx_class(pause_tx_class), .pause_tx_quanta(pause_tx_quanta)
);

// >>> tb/tpq_partner.sv
// Transmit datapath model: takes pause offers, may stall or hold a packet
`timescale 1ns/10ps
module tpq_partner (
    // Clock, reset and test controls
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        busy,
    input  wire logic [1:0]  lag,
    // Offer port
    input  wire logic        pause_tx_valid,
    input  wire logic        pause_tx_global,
    input  wire logic [3:0]  pause_tx_class,
    input  wire logic [15:0] pause_tx_quanta,
    output logic             pkt_in_flight,
    output logic             pause_tx_ready,
    // Traffic seen
    output int               sent_ff,
    output logic [20:0]      last_ff
);
    logic [1:0] wait_ff;
    // A data packet in flight blocks every launch
    assign pkt_in_flight = busy;
    // Slow acceptance tests that the offer is held
    assign pause_tx_ready = pause_tx_valid && (wait_ff == lag);
    always_ff @(posedge mclk) begin
        if (reset || pause_tx_ready) begin
            wait_ff <= 2'h0;
        end else if (pause_tx_valid) begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
    // Record each accepted pause packet
    always_ff @(posedge mclk) begin
        if (reset) begin
            sent_ff <= 0;
            last_ff <= 21'h000000;
        end else if (pause_tx_ready) begin
            sent_ff <= sent_ff + 1;
            last_ff <= {pause_tx_global, pause_tx_class, pause_tx_quanta};
        end
    end
endmodule : tpq_partner

// >>> tb/test_tpq_ctrl.sv
// Self-checking bench for the pause quanta and resend control
`timescale 1ns/10ps
`include "tpq_regs.svh"
module test_tpq_ctrl import tpq_pkg::*; ;
    logic             mclk = 1'b0, reset = 1'b1, resend_pause = 1'b0, busy = 1'b0;
    logic [8:0]       pause_req = 9'h000, pause_enable = 9'h1FF;
    logic [8:0][15:0] pause_quanta, refresh_timer;
    logic [1:0]       lag = 2'h0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic             pkt_in_flight, pause_tx_ready, pause_tx_valid, pause_tx_global;
    logic             pready, pslverr, er;
    logic [3:0]       pause_tx_class;
    logic [15:0]      pause_tx_quanta;
    logic [20:0]      last;
    int               miscompares = 0, samples_checked = 0, sent, c;
    always #10 mclk = ~mclk;
    tpq_ctrl #(.NCLS(9), .QW(16), .REG_IF(1'b0)) dut (.mclk(mclk), .reset(reset),
        .pause_req(pause_req), .pause_enable(pause_enable), .resend_pause(resend_pause),
        .pause_quanta(pause_quanta), .refresh_timer(refresh_timer),
        .pkt_in_flight(pkt_in_flight), .pause_tx_ready(pause_tx_ready),
        .pause_tx_valid(pause_tx_valid), .pause_tx_global(pause_tx_global),
        .pause_tx_class(pause_tx_class), .pause_tx_quanta(pause_tx_quanta),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    tpq_partner u_dp (.mclk(mclk), .reset(reset), .busy(busy), .lag(lag),
        .pause_tx_valid(pause_tx_valid), .pause_tx_global(pause_tx_global),
        .pause_tx_class(pause_tx_class), .pause_tx_quanta(pause_tx_quanta),
        .pkt_in_flight(pkt_in_flight), .pause_tx_ready(pause_tx_ready),
        .sent_ff(sent), .last_ff(last));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // APB transfer; the answer is awaited, never assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel twice in one step
        @(posedge mclk);
    endtask : apb
    // Wait up to n cycles for the next accepted packet; c holds cycles waited
    task wt(input int n, input bit must);
        int s;
        s = sent;
        c = 0;
        while (sent == s && c < n) begin
            @(posedge mclk);
            c++;
        end
        if (must && sent == s) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask : wt
    // One-cycle resend pulse, never held longer
    task pulse;
        resend_pause <= 1'b1;
        @(posedge mclk);
        resend_pause <= 1'b0;
    endtask : pulse
    initial begin
        for (int k = 0; k < 9; k++) begin
            pause_quanta[k] = 16'hA500 + 16'(k);
            refresh_timer[k] = 16'h0000;
        end
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        // Register reset values, write-back and an unmapped place
        apb(1'b0, `TPQ_ADDR_QUANTA_BASE, 32'h0);
        chk(rd, 32'h0000_FFFF);
        apb(1'b0, `TPQ_ADDR_REFRESH_BASE + 12'h020, 32'h0);
        chk(rd, 32'h0000_7FFF);
        apb(1'b1, `TPQ_ADDR_ENABLE, 32'h0000_01A5);
        apb(1'b0, `TPQ_ADDR_ENABLE, 32'h0);
        chk(rd, 32'h0000_01A5);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        // Every class, then a resend of it, with varied acceptance delay
        for (int k = 0; k < 9; k++) begin
            lag <= k[1:0];
            pause_req <= 9'h001 << k;
            wt(20, 1'b1);
            chk(32'(last), {11'h0, k == 8, 4'(k), 16'hA500 + 16'(k)});
            pulse();
            wt(20, 1'b1);
            chk(32'(last[19:16]), 32'(k));
            pause_req <= 9'h000;
            @(posedge mclk);
        end
        // A disabled class stays silent
        pause_enable <= 9'h1FB;
        pause_req <= 9'h004;
        wt(20, 1'b0);
        chk(32'(c), 32'h14);
        pause_enable <= 9'h1FF;
        // Resend waits for the packet in flight
        pause_req <= 9'h020;
        wt(20, 1'b1);
        busy <= 1'b1;
        pulse();
        wt(12, 1'b0);
        chk(32'(c), 32'h0C);
        busy <= 1'b0;
        wt(12, 1'b1);
        chk(32'(last[19:16]), 32'h5);
        pause_req <= 9'h000;
        @(posedge mclk);
        // Resend with nothing pending sends nothing
        pulse();
        wt(16, 1'b0);
        chk(32'(c), 32'h10);
        // Refresh spacing, and restart of it by resend
        refresh_timer[1] <= 16'h0014;
        pause_req <= 9'h002;
        wt(20, 1'b1);
        wt(40, 1'b1);
        chk(32'(c > 17 && c < 27), 32'h1);
        repeat (8) @(posedge mclk);
        pulse();
        wt(8, 1'b1);
        wt(40, 1'b1);
        chk(32'(c > 15), 32'h1);
        results();
    end
endmodule : test_tpq_ctrl
